/* design/sep_eeprom_core.sv */
// Serial EEPROM command decoder, status register, protection and array.
`timescale 1ns/1ps
`include "sep_regs.svh"

// Behaviour
// - Chip select high: serial input ignored, serial output floats.
// - Input sampled on rising clock, output changes after falling clock.
// - Works in clock modes 0 and 3.
// - Frame starts at select fall, 8-bit instruction, all fields MSB first.
// - Decode set latch, clear latch, status read; bit 3 ignored.
// - Decode status write, array read, array write; bit 3 ignored.
// - Status bit 0 is one while an internal write runs.
// - Status bit 1 shows the write latch.
// - Bits 4 to 6 read zero; all bits read one while busy.
// - Write latch clear after reset; master sets it before each write.
// - Clear latch instruction works whatever the guard pin level.
// - Block guard bits select none, top quarter, top half or all.
// - Guard bits are stored cells, updated by a self-timed write.
// - Guard pin low with pin enable blocks status and guarded writes.
// - Array and status writes need the write latch set.
// - Guard pin falling during a running write changes nothing.
// - Pin enable cannot be cleared while the guard pin stays low.
// - Hold pauses a frame without losing its state.
// - While held, output floats and input and clock are ignored.
// - Array of 128 pages by 32 bytes, 12-bit byte address.
// - Each write is self-timed; busy stays set throughout.
// - Array read address increments and wraps to zero.
// - Page write increments only the five low address bits.
// - Write latch clears when an internal write completes.
// - While busy, only the status read instruction is obeyed.
module sep_eeprom_core #(
    parameter int ADDR_W       = `SEP_ADDR_W,
    parameter int PAGE_BYTES   = `SEP_PAGE_BYTES,
    parameter int WRITE_CYCLES = `SEP_TWC_CYCLES
) (
    // System clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Serial link
    input  wire logic sclk,
    input  wire logic csN,
    input  wire logic siData,
    output logic      soData,
    output logic      soOe,
    // Pause and guard pins
    input  wire logic holdN,
    input  wire logic wpN
);

    localparam int OFS_W = $clog2(PAGE_BYTES);
    localparam int TIM_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [TIM_W-1:0] TIM_LAST = TIM_W'(WRITE_CYCLES - 1);

    // ---------------- Serial clock domain ----------------
    logic                    fresh;
    logic                    frameTog;
    logic [2:0]              bitCnt;
    logic [2:0]              byteCnt;
    logic [7:0]              rxShift;
    logic [7:0]              txByte;
    logic [7:0]              stData;
    logic [ADDR_W-1:0]       addr;
    logic [7:0]              pageBuf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0]   pageMask;
    logic                    soDrive;
    logic [1:0]              busySync;
    logic [1:0]              latchSync;
    sep_pkg::sep_op_type     reqOp;

    // ---------------- System clock domain ----------------
    logic [7:0]              mem [0:(1<<ADDR_W)-1];
    logic [2:0]              csPipe;
    logic [2:0]              wpPipe;
    logic                    csLevel;
    logic                    wpLevel;
    logic                    lastTog;
    logic                    writeLatch;
    logic                    guardLo;
    logic                    guardHi;
    logic                    guardPinEnable;
    logic [TIM_W-1:0]        timer;
    sep_pkg::sep_sys_type    sysState;

    // A new frame is marked by select high; the first rising edge clears it.
    wire frameRst = csN | ~nrst;
    // Hold only moves while the clock is low, so it is stable at each edge.
    wire linkRun  = ~csN & holdN;

    always_ff @(posedge sclk or posedge frameRst) begin
        if (frameRst) begin
            fresh <= 1'b1;
        end else if (holdN) begin
            fresh <= 1'b0;
        end
    end

    wire                  busyS    = busySync[1];
    wire                  latchS   = latchSync[1];
    wire [2:0]            curBit   = fresh ? 3'h0 : bitCnt;
    wire [2:0]            curByte  = fresh ? 3'h0 : byteCnt;
    wire [7:0]            rxByte   = {rxShift[6:0], siData};
    wire                  byteDone = linkRun && (curBit == 3'h7);
    wire [7:0]            opcBits  = rxByte & `SEP_OPC_MASK;
    wire                  opDataIn = (curByte >= 3'h3);
    wire [ADDR_W-1:0]     rdAddr   = {addr[ADDR_W-1:8], rxByte};

    // Instruction decode with bit 3 masked off.
    sep_pkg::sep_op_type rawOp;
    sep_pkg::sep_op_type gatedOp;
    sep_pkg::sep_op_type curOp;
    sep_pkg::sep_op_type opNow;
    assign rawOp =
        (opcBits == `SEP_OPC_SETL)  ? sep_pkg::SEP_OP_SETL  :
        (opcBits == `SEP_OPC_CLRL)  ? sep_pkg::SEP_OP_CLRL  :
        (opcBits == `SEP_OPC_RDST)  ? sep_pkg::SEP_OP_RDST  :
        (opcBits == `SEP_OPC_WRST)  ? sep_pkg::SEP_OP_WRST  :
        (opcBits == `SEP_OPC_READ)  ? sep_pkg::SEP_OP_READ  :
        (opcBits == `SEP_OPC_WRITE) ? sep_pkg::SEP_OP_WRITE :
        sep_pkg::SEP_OP_NONE;
    assign gatedOp = (busyS && rawOp != sep_pkg::SEP_OP_RDST) ?
                     sep_pkg::SEP_OP_NONE : rawOp;
    assign curOp   = fresh ? sep_pkg::SEP_OP_NONE : reqOp;
    assign opNow   = (curByte == 3'h0) ? gatedOp : curOp;

    // Status view as seen by the serial side.
    logic [7:0] stView;
    always_comb begin
        stView                 = 8'h00;
        stView[`SEP_SB_LATCH]  = latchS;
        stView[`SEP_SB_GLO]    = guardLo;
        stView[`SEP_SB_GHI]    = guardHi;
        stView[`SEP_SB_GPE]    = guardPinEnable;
        if (busyS) begin
            stView = `SEP_STATUS_BUSY;
        end
    end

    // Busy and latch change rarely; two flops on the link clock suffice.
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            busySync  <= 2'h0;
            latchSync <= 2'h0;
        end else begin
            busySync  <= {busySync[0], sysState == sep_pkg::SEP_SYS_PROG};
            latchSync <= {latchSync[0], writeLatch};
        end
    end

    // Bit and byte framing, sampled on the rising edge in either mode.
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            bitCnt   <= 3'h0;
            byteCnt  <= 3'h0;
            rxShift  <= 8'h00;
            reqOp    <= sep_pkg::SEP_OP_NONE;
            frameTog <= 1'b0;
        end else if (linkRun) begin
            bitCnt  <= curBit + 3'h1;
            rxShift <= rxByte;
            reqOp   <= byteDone ? opNow : curOp;
            byteCnt <= (byteDone && curByte != 3'h4) ?
                       curByte + 3'h1 : curByte;
            if (fresh) begin
                frameTog <= ~frameTog;
            end
        end
    end

    // Address, page buffer and transmit byte.
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            addr     <= '0;
            txByte   <= 8'h00;
            stData   <= 8'h00;
            pageMask <= '0;
        end else if (linkRun) begin
            if (fresh) begin
                pageMask <= '0;
            end
            if (byteDone) begin
                case (opNow)
                    sep_pkg::SEP_OP_RDST: begin
                        txByte <= stView;
                    end
                    sep_pkg::SEP_OP_WRST: begin
                        if (curByte == 3'h1) begin
                            stData <= rxByte;
                        end
                    end
                    sep_pkg::SEP_OP_READ: begin
                        if (curByte == 3'h1) begin
                            addr[ADDR_W-1:8] <= rxByte[ADDR_W-9:0];
                        end else if (curByte == 3'h2) begin
                            txByte <= mem[rdAddr];
                            addr   <= rdAddr + 1'b1;
                        end else if (opDataIn) begin
                            txByte <= mem[addr];
                            addr   <= addr + 1'b1;
                        end
                    end
                    sep_pkg::SEP_OP_WRITE: begin
                        if (curByte == 3'h1) begin
                            addr[ADDR_W-1:8] <= rxByte[ADDR_W-9:0];
                        end else if (curByte == 3'h2) begin
                            addr[7:0] <= rxByte;
                        end else if (opDataIn) begin
                            pageMask[addr[OFS_W-1:0]] <= 1'b1;
                            addr[OFS_W-1:0] <= addr[OFS_W-1:0] + 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // The page buffer holds data only, so it needs no reset.
    always_ff @(posedge sclk) begin
        if (byteDone && opDataIn && curOp == sep_pkg::SEP_OP_WRITE) begin
            pageBuf[addr[OFS_W-1:0]] <= rxByte;
        end
    end

    // Output moves after the falling edge; deselect drops the enable at once.
    always_ff @(negedge sclk or posedge frameRst) begin
        if (frameRst) begin
            soData  <= 1'b0;
            soDrive <= 1'b0;
        end else if (linkRun) begin
            soData  <= txByte[~bitCnt];
            soDrive <= ~fresh && (reqOp == sep_pkg::SEP_OP_RDST ||
                       (reqOp == sep_pkg::SEP_OP_READ && byteCnt >= 3'h3));
        end
    end

    // Select and hold are pins with no clock of their own, so the enable
    // has to follow them at once rather than wait for an edge.
    assign soOe = soDrive & linkRun;

    // ---------------- System clock domain ----------------
    // The link logic is quiet once select is high, so its frame fields are
    // stable when the synchronised select rise is seen here.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            csPipe  <= 3'h7;
            wpPipe  <= 3'h7;
            csLevel <= 1'b1;
            wpLevel <= 1'b1;
        end else begin
            csPipe <= {csPipe[1:0], csN};
            wpPipe <= {wpPipe[1:0], wpN};
            if (csPipe[1] == csPipe[2]) begin
                csLevel <= csPipe[2];
            end
            if (wpPipe[1] == wpPipe[2]) begin
                wpLevel <= wpPipe[2];
            end
        end
    end

    wire idle     = sysState == sep_pkg::SEP_SYS_IDLE;
    wire csRise   = (csPipe[1] == csPipe[2]) && csPipe[2] && !csLevel;
    wire commit   = csRise && (frameTog != lastTog) && idle &&
                    bitCnt == 3'h0;
    wire hwGuard  = !wpLevel && guardPinEnable;
    wire [1:0] level = {guardHi, guardLo};
    wire pageProt = (level == 2'h1 && addr >= `SEP_PROT_L1) ||
                    (level == 2'h2 && addr >= `SEP_PROT_L2) ||
                    (level == 2'h3 && addr >= `SEP_PROT_L3);
    wire doStat   = commit && reqOp == sep_pkg::SEP_OP_WRST &&
                    byteCnt >= 3'h2 && writeLatch && !hwGuard;
    wire doArray  = commit && reqOp == sep_pkg::SEP_OP_WRITE &&
                    byteCnt == 3'h4 && writeLatch && !pageProt;
    wire doSet    = commit && reqOp == sep_pkg::SEP_OP_SETL;
    wire doClr    = commit && reqOp == sep_pkg::SEP_OP_CLRL;
    wire timeUp   = !idle && timer == TIM_LAST;

    // Write cycle sequencer; protection is judged only at the start.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sysState <= sep_pkg::SEP_SYS_IDLE;
            timer    <= '0;
            lastTog  <= 1'b0;
        end else begin
            if (csRise) begin
                lastTog <= frameTog;
            end
            case (sysState)
                sep_pkg::SEP_SYS_IDLE: begin
                    timer <= '0;
                    if (doStat || doArray) begin
                        sysState <= sep_pkg::SEP_SYS_PROG;
                    end
                end
                sep_pkg::SEP_SYS_PROG: begin
                    timer <= timer + 1'b1;
                    if (timeUp) begin
                        sysState <= sep_pkg::SEP_SYS_IDLE;
                    end
                end
                default: begin
                    sysState <= sep_pkg::SEP_SYS_IDLE;
                end
            endcase
        end
    end

    // Write latch and the stored guard bits.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            writeLatch     <= 1'b0;
            guardLo        <= `SEP_NV_RESET;
            guardHi        <= `SEP_NV_RESET;
            guardPinEnable <= `SEP_NV_RESET;
        end else begin
            if (doSet) begin
                writeLatch <= 1'b1;
            end else if (doClr || timeUp) begin
                writeLatch <= 1'b0;
            end
            if (doStat) begin
                guardLo        <= stData[`SEP_SB_GLO];
                guardHi        <= stData[`SEP_SB_GHI];
                guardPinEnable <= stData[`SEP_SB_GPE];
            end
        end
    end

    // Only the page bytes received in the frame are written, at the start of the cycle.
    always_ff @(posedge clk_sys) begin
        if (doArray) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pageMask[i]) begin
                    mem[{addr[ADDR_W-1:OFS_W], OFS_W'(i)}] <= pageBuf[i];
                end
            end
        end
    end

    // ---------------- Checks ----------------
    chk_deselect_float: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        csLevel && csPipe[2] |-> !soOe)
        else $error("Output driven while deselected.");

    chk_busy_status_ones: assert property (
        @(posedge sclk) disable iff (!nrst)
        byteDone && opNow == sep_pkg::SEP_OP_RDST && busyS
        |=> txByte == `SEP_STATUS_BUSY)
        else $error("Status not all ones while busy.");

    chk_busy_ignores_cmd: assert property (
        @(posedge sclk) disable iff (!nrst)
        byteDone && curByte == 3'h0 && busyS &&
        rawOp != sep_pkg::SEP_OP_RDST
        |=> reqOp == sep_pkg::SEP_OP_NONE)
        else $error("Instruction accepted while busy.");

    chk_latch_autoclear: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        timeUp |=> !writeLatch && idle)
        else $error("Latch not cleared after write cycle.");

    chk_busy_holds: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        idle && (doStat || doArray) |=> !idle [*2])
        else $error("Write cycle ended too soon.");

    chk_no_latch_write: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        idle && !writeLatch |=> idle && $stable(guardPinEnable))
        else $error("Write started without latch.");

    chk_pin_guard_stat: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        idle && hwGuard |=> guardPinEnable)
        else $error("Pin enable cleared under guard.");

    chk_clear_latch: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        doClr |=> !writeLatch)
        else $error("Clear latch instruction lost.");

    chk_page_wrap: assert property (
        @(posedge sclk) disable iff (!nrst)
        byteDone && opDataIn && curOp == sep_pkg::SEP_OP_WRITE
        |=> addr[ADDR_W-1:OFS_W] == $past(addr[ADDR_W-1:OFS_W]))
        else $error("Page write moved the page.");

    chk_read_increment: assert property (
        @(posedge sclk) disable iff (!nrst)
        byteDone && opDataIn && curOp == sep_pkg::SEP_OP_READ
        |=> addr == $past(addr) + 1'b1)
        else $error("Read address did not advance.");

    chk_hold_freeze: assert property (
        @(posedge sclk) disable iff (!nrst)
        !holdN && !csN && !fresh |=> $stable(bitCnt))
        else $error("Clock counted while held.");

    cov_array_write: cover property (
        @(posedge clk_sys) disable iff (!nrst) doArray);
    cov_status_write: cover property (
        @(posedge clk_sys) disable iff (!nrst) doStat);
    cov_busy_poll: cover property (
        @(posedge sclk) disable iff (!nrst)
        byteDone && opNow == sep_pkg::SEP_OP_RDST && busyS);
    cov_guard_refuse: cover property (
        @(posedge clk_sys) disable iff (!nrst)
        commit && reqOp == sep_pkg::SEP_OP_WRST && hwGuard);

endmodule // sep_eeprom_core

/* design/sep_regs.svh */
// Constants of the serial EEPROM command and protection block.
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH

// Instruction codes: low three bits, bit 3 is ignored, top nibble is zero.
`define SEP_OPC_MASK       8'hF7
`define SEP_OPC_SETL       8'h06
`define SEP_OPC_CLRL       8'h04
`define SEP_OPC_RDST       8'h05
`define SEP_OPC_WRST       8'h01
`define SEP_OPC_READ       8'h03
`define SEP_OPC_WRITE      8'h02

// Status register field positions and values.
`define SEP_SB_BUSY        0
`define SEP_SB_LATCH       1
`define SEP_SB_GLO         2
`define SEP_SB_GHI         3
`define SEP_SB_GPE         7
`define SEP_STATUS_BUSY    8'hFF
`define SEP_NV_RESET       1'b0

// Array organisation.
`define SEP_ADDR_W         12
`define SEP_PAGE_BYTES     32

// Lowest protected address for each block guard level.
`define SEP_PROT_L1        12'hC00
`define SEP_PROT_L2        12'h800
`define SEP_PROT_L3        12'h000

// Self-timed write: longest time, rounded down to system clock cycles.
// Worked in nanoseconds so that the product stays inside a 32-bit integer.
`define SEP_CLK_PS         4000
`define SEP_TWC_MS         5
`define SEP_TWC_CYCLES     ((`SEP_TWC_MS * 1000000) / (`SEP_CLK_PS / 1000))

`endif

/* design/sep_pkg.sv */
// Types shared by the serial EEPROM command and protection block.
package sep_pkg;

    typedef enum logic [2:0] {
        SEP_OP_NONE  = 3'b000,
        SEP_OP_SETL  = 3'b001,
        SEP_OP_CLRL  = 3'b010,
        SEP_OP_RDST  = 3'b011,
        SEP_OP_WRST  = 3'b100,
        SEP_OP_READ  = 3'b101,
        SEP_OP_WRITE = 3'b110
    } sep_op_type;

    typedef enum logic {
        SEP_SYS_IDLE = 1'b0,
        SEP_SYS_PROG = 1'b1
    } sep_sys_type;

endpackage

/* tb/sep_spi_master.sv */
// Serial bus master model that frames, clocks and pauses transfers.
`timescale 1ns/1ps
module sep_spi_master (
    // Serial link
    output logic      sclk,
    output logic      csN,
    output logic      siData,
    input  wire logic soData,
    input  wire logic soOe,
    // Pause pin
    output logic      holdN
);
    logic idleHigh;

    initial begin
        idleHigh = 1'b0;
        sclk = 1'b0;
        csN = 1'b1;
        siData = 1'b0;
        holdN = 1'b1;
    end

    // The odd start delay keeps the link clock out of phase with clk_sys.
    task automatic open_frame(input logic mode3);
        idleHigh = mode3;
        sclk = mode3;
        #33;
        csN = 1'b0;
        #30;
    endtask

    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                        output logic oe);
        oe = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            siData = tx[i];
            #40;
            sclk = 1'b1;
            rx[i] = soData;
            oe = oe & soOe;
            #40;
        end
    endtask

    // A released data line shows the inverse, never the last value.
    task automatic close_frame();
        sclk = idleHigh;
        #40;
        csN = 1'b1;
        siData = ~siData;
        #120;
    endtask

    // Clock edges during the pause must leave the frame where it was.
    task automatic pause(output logic oeHeld);
        sclk = 1'b0;
        #20;
        holdN = 1'b0;
        repeat (3) begin
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        #20;
        oeHeld = soOe;
        holdN = 1'b1;
        #20;
    endtask
endmodule // sep_spi_master

/* tb/tb.sv */
// Self-checking bench for the serial EEPROM command and protection block.
`timescale 1ns/1ps
module tb;
    typedef struct {
        logic [7:0] op;
        logic [7:0] rdOp;
        logic       mode3;
        logic [7:0] st;
    } sep_row_type;

    sep_row_type rows [5] = '{
        '{8'h06, 8'h05, 1'b0, 8'h02}, '{8'h04, 8'h0D, 1'b1, 8'h00},
        '{8'h0E, 8'h05, 1'b1, 8'h02}, '{8'h0C, 8'h0D, 1'b0, 8'h00},
        '{8'h06, 8'h0D, 1'b1, 8'h02}};

    logic       clk_sys;
    logic       nrst;
    logic       wpN;
    wire        sclk;
    wire        csN;
    wire        siData;
    wire        soData;
    wire        soOe;
    wire        holdN;
    logic [7:0] rx;
    logic [7:0] st;
    logic [7:0] v;
    logic [7:0] e01;
    logic [1:0] lv;
    logic       oe;
    int         failures = 0;
    int         comparisons = 0;

    sep_eeprom_core #(.WRITE_CYCLES(1000)) dut_u (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .sclk    (sclk),
        .csN     (csN),
        .siData  (siData),
        .soData  (soData),
        .soOe    (soOe),
        .holdN   (holdN),
        .wpN     (wpN)
    );

    sep_spi_master m_u (
        .sclk   (sclk),
        .csN    (csN),
        .siData (siData),
        .soData (soData),
        .soOe   (soOe),
        .holdN  (holdN)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op);
        m_u.open_frame(1'b0);
        m_u.xfer(op, rx, oe);
        m_u.close_frame();
        chk({7'h00, soOe}, 8'h00);
    endtask

    task automatic status(input logic [7:0] op, input logic mode3);
        m_u.open_frame(mode3);
        m_u.xfer(op, rx, oe);
        chk({7'h00, oe}, 8'h00);
        m_u.xfer(8'h00, st, oe);
        m_u.close_frame();
    endtask

    // Polling is bounded; a write that never ends closes the run.
    task automatic wait_ready();
        for (int n = 0; n < 40; n++) begin
            status(8'h05, 1'b0);
            if (st[0] === 1'b0) return;
        end
        failures++;
        $display("unexpected at %0t: device stays busy", $time);
        conclude();
    endtask

    task automatic wr(input logic [7:0] op, input logic [11:0] a,
                      input logic [7:0] d[$], input logic latch);
        if (latch) cmd(8'h06);
        m_u.open_frame(1'b0);
        m_u.xfer(op, rx, oe);
        if (op[1]) begin
            m_u.xfer({4'h0, a[11:8]}, rx, oe);
            m_u.xfer(a[7:0], rx, oe);
        end
        foreach (d[i]) m_u.xfer(d[i], rx, oe);
        m_u.close_frame();
    endtask

    task automatic rd(input logic [7:0] op, input logic [11:0] a,
                      input logic [7:0] e[$], input logic hld);
        m_u.open_frame(1'b0);
        m_u.xfer(op, rx, oe);
        m_u.xfer({4'h0, a[11:8]}, rx, oe);
        m_u.xfer(a[7:0], rx, oe);
        foreach (e[i]) begin
            if (hld) begin
                m_u.pause(oe);
                chk({7'h00, oe}, 8'h00);
            end
            m_u.xfer(8'h00, rx, oe);
            chk(rx, e[i]);
            chk({7'h00, oe}, 8'h01);
        end
        m_u.close_frame();
        chk({7'h00, soOe}, 8'h00);
    endtask

    initial begin
        nrst = 1'b0;
        wpN = 1'b1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        status(8'h05, 1'b0);
        chk(st, 8'h00);
        foreach (rows[i]) begin
            cmd(rows[i].op);
            status(rows[i].rdOp, rows[i].mode3);
            chk(st, rows[i].st);
        end
        wr(8'h0A, 12'h01E, '{8'hA0, 8'hA1, 8'hA2}, 1'b1);
        status(8'h05, 1'b0);
        chk(st, 8'hFF);
        cmd(8'h06);
        wait_ready();
        chk(st, 8'h00);
        wr(8'h02, 12'hFFF, '{8'hB0, 8'hB1}, 1'b1);
        wait_ready();
        rd(8'h03, 12'hFE0, '{8'hB1}, 1'b0);
        rd(8'h0B, 12'h01E, '{8'hA0, 8'hA1}, 1'b0);
        rd(8'h03, 12'hFFF, '{8'hB0, 8'hA2}, 1'b0);
        rd(8'h03, 12'hFFF, '{8'hB0, 8'hA2}, 1'b1);
        wr(8'h02, 12'h01E, '{8'h5A}, 1'b0);
        status(8'h05, 1'b0);
        chk(st, 8'h00);
        e01 = 8'hA0;
        for (int l = 1; l < 4; l++) begin
            lv = 2'(l);
            v = 8'h70 + 8'(l);
            wr(8'h01, 12'h000, '{{4'h0, lv, 2'b00}}, 1'b1);
            wait_ready();
            chk(st, {4'h0, lv, 2'b00});
            wr(8'h02, 12'hFFF, '{v}, 1'b1);
            wait_ready();
            wr(8'h02, 12'h01E, '{v}, 1'b1);
            wait_ready();
            e01 = (l == 3) ? e01 : v;
            rd(8'h03, 12'hFFF, '{8'hB0}, 1'b0);
            rd(8'h03, 12'h01E, '{e01}, 1'b0);
        end
        wr(8'h09, 12'h000, '{8'h80}, 1'b1);
        @(negedge clk_sys) wpN = 1'b0;
        wait_ready();
        chk(st, 8'h80);
        wr(8'h01, 12'h000, '{8'h00}, 1'b1);
        wait_ready();
        chk(st, 8'h82);
        cmd(8'h04);
        status(8'h05, 1'b0);
        chk(st, 8'h80);
        @(negedge clk_sys) wpN = 1'b1;
        wr(8'h01, 12'h000, '{8'h00}, 1'b1);
        wait_ready();
        chk(st, 8'h00);
        // A reset in mid-run must drop a latch that was set just before.
        cmd(8'h06);
        @(negedge clk_sys) nrst = 1'b0;
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        status(8'h05, 1'b0);
        chk(st, 8'h00);
        conclude();
    end
endmodule // tb
